// ==== hw/ptt_pkg.sv ====
`default_nettype none
package ptt_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_COUNTER = 8'h00;
   localparam logic [7:0] ADDR_PRELOAD = 8'h04;
   localparam logic [7:0] ADDR_TAP_CTRL = 8'h08;
   localparam logic [7:0] ADDR_CMP_ONE = 8'h0c;
   localparam logic [7:0] ADDR_CMP_TWO = 8'h10;
   localparam logic [7:0] ADDR_CMP_CTRL = 8'h14;
   localparam logic [7:0] ADDR_CNT_EN = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int TICK_W = 21;
   localparam int PRESC_W = 11;
   localparam int TAPSEL_LSB = 11;
   localparam int TAP_FLAG_BIT = 7;
   localparam int TAP_ENA_BIT = 6;
   localparam int COMPARE_ONE_FLAG_BIT = 7;
   localparam int COMPARE_TWO_FLAG_BIT = 6;
   localparam int COMPARE_ONE_ENABLE_BIT = 5;
   localparam int COMPARE_TWO_ENABLE_BIT = 4;
   localparam int EVT_W = 3;
   localparam int EVT_TAP = 0;
   localparam int EVT_CMP1 = 1;
   localparam int EVT_CMP2 = 2;
   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [10:0] PRELOAD_RST = 11'h000;
   localparam logic [2:0] TAPSEL_RST = 3'h0;
   localparam logic [2:0] TAPSEL_UNDERFLOW = 3'h7;
   localparam logic [1:0] COUNT_MODE_ENABLE_RST = 2'h0;
   localparam logic [4:0] TAP_BIT_TOP = 5'h14;
   localparam logic [4:0] TAP_BIT_STEP = 5'h03;
   typedef enum logic [1:0] {
      PTT_CNT_ALL = 2'b00,
      PTT_CNT_PRIV = 2'b01,
      PTT_CNT_USER = 2'b10,
      PTT_CNT_NONE = 2'b11
   } ptt_cnt_mode_t;
endpackage
`default_nettype wire

// ==== hw/ptt_timer.sv ====
`default_nettype none
// Overview of operation
// - Prescaler decrements; at zero reloads, tick increments
// - Privileged counter write clears tick, reloads prescaler
// - Counter word: tick high, prescaler low
// - Reset clears both counters
// - Tap select picks tick bit or underflow
// - Preload copied into prescaler at zero
// - Tap flag sets on falling tap bit
// - Privileged zero write clears tap flag
// - Tap enable gates tap interrupt request
// - Compare flag one sets on match one
// - Compare flag two sets on match two
// - Compare flags bits 7,6; zero clears
// - Enables bits 5,4 gate compare requests
// - Count enable field selects allowed modes
// - Writes only in privilege; reads always
// - Reserved bits ignore writes, read zero
module ptt_timer #(
   parameter int TICK_W = ptt_pkg::TICK_W,
   parameter int PRESC_W = ptt_pkg::PRESC_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cpu_priv,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic tap_irq,
   output logic cmp_one_irq,
   output logic cmp_two_irq,
   output logic irq
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [TICK_W-1:0] tick_counter_r;
   logic [PRESC_W-1:0] prescaler_counter_r;
   logic [PRESC_W-1:0] preload_value_r;
   logic [2:0] tap_select_r;
   logic tap_event_flag_r;
   logic tap_irq_enable_r;
   logic [TICK_W-1:0] cmp_one_r;
   logic [TICK_W-1:0] cmp_two_r;
   logic compare_one_flag_r;
   logic compare_two_flag_r;
   logic compare_one_enable_r;
   logic compare_two_enable_r;
   logic [1:0] count_mode_enable_r;
   logic [ptt_pkg::EVT_W-1:0] irq_status_r;
   logic [ptt_pkg::EVT_W-1:0] irq_mask_r;
   logic tap_prev_r;
   logic [TICK_W-1:0] tick_prev_r;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic acc;
   logic wr;
   logic known;
   assign acc = psel && penable;
   assign pready = 1'b1;
   always_comb begin
      case (paddr)
         ptt_pkg::ADDR_COUNTER, ptt_pkg::ADDR_PRELOAD,
         ptt_pkg::ADDR_TAP_CTRL, ptt_pkg::ADDR_CMP_ONE,
         ptt_pkg::ADDR_CMP_TWO, ptt_pkg::ADDR_CMP_CTRL,
         ptt_pkg::ADDR_CNT_EN, ptt_pkg::ADDR_IRQ_STATUS,
         ptt_pkg::ADDR_IRQ_MASK: known = 1'b1;
         default: known = 1'b0;
      endcase
   end
   assign pslverr = acc && (!known || (pwrite && !cpu_priv));
   assign wr = acc && pwrite && cpu_priv && known;
   logic wr_cnt, wr_tap, wr_cmpc, wr_sts;
   assign wr_cnt = wr && (paddr == ptt_pkg::ADDR_COUNTER);
   assign wr_tap = wr && (paddr == ptt_pkg::ADDR_TAP_CTRL);
   assign wr_cmpc = wr && (paddr == ptt_pkg::ADDR_CMP_CTRL);
   assign wr_sts = wr && (paddr == ptt_pkg::ADDR_IRQ_STATUS);

   // ----------------------------------------------------------------
   // Counting
   // ----------------------------------------------------------------
   logic count_ok;
   logic underflow;
   always_comb begin
      case (ptt_pkg::ptt_cnt_mode_t'(count_mode_enable_r))
         ptt_pkg::PTT_CNT_ALL: count_ok = 1'b1;
         ptt_pkg::PTT_CNT_PRIV: count_ok = cpu_priv;
         ptt_pkg::PTT_CNT_USER: count_ok = !cpu_priv;
         ptt_pkg::PTT_CNT_NONE: count_ok = 1'b0;
         default: count_ok = 1'b0;
      endcase
   end
   assign underflow = count_ok && (prescaler_counter_r == '0);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prescaler_counter_r <= '0;
         tick_counter_r <= '0;
      end else if (wr_cnt) begin
         prescaler_counter_r <= preload_value_r;
         tick_counter_r <= '0;
      end else if (underflow) begin
         prescaler_counter_r <= preload_value_r;
         tick_counter_r <= tick_counter_r + 1'b1;
      end else if (count_ok) begin
         prescaler_counter_r <= prescaler_counter_r - 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         preload_value_r <= ptt_pkg::PRELOAD_RST;
         tap_select_r <= ptt_pkg::TAPSEL_RST;
         cmp_one_r <= '0;
         cmp_two_r <= '0;
         count_mode_enable_r <= ptt_pkg::COUNT_MODE_ENABLE_RST;
         tap_irq_enable_r <= 1'b0;
         compare_one_enable_r <= 1'b0;
         compare_two_enable_r <= 1'b0;
         irq_mask_r <= '0;
      end else if (wr) begin
         case (paddr)
            ptt_pkg::ADDR_PRELOAD: begin
               preload_value_r <= pwdata[PRESC_W-1:0];
               tap_select_r <= pwdata[ptt_pkg::TAPSEL_LSB +: 3];
            end
            ptt_pkg::ADDR_TAP_CTRL:
               tap_irq_enable_r <= pwdata[ptt_pkg::TAP_ENA_BIT];
            ptt_pkg::ADDR_CMP_ONE: cmp_one_r <= pwdata[TICK_W-1:0];
            ptt_pkg::ADDR_CMP_TWO: cmp_two_r <= pwdata[TICK_W-1:0];
            ptt_pkg::ADDR_CMP_CTRL: begin
               compare_one_enable_r <= pwdata[ptt_pkg::COMPARE_ONE_ENABLE_BIT];
               compare_two_enable_r <= pwdata[ptt_pkg::COMPARE_TWO_ENABLE_BIT];
            end
            ptt_pkg::ADDR_CNT_EN: count_mode_enable_r <= pwdata[1:0];
            ptt_pkg::ADDR_IRQ_MASK:
               irq_mask_r <= pwdata[ptt_pkg::EVT_W-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------
   logic [4:0] tap_idx;
   logic tap_bit;
   logic tap_hit;
   logic hit_one;
   logic hit_two;
   assign tap_idx = 5'(ptt_pkg::TAP_BIT_TOP
                    - 5'(tap_select_r * ptt_pkg::TAP_BIT_STEP));
   // Underflow code has no counter bit; park the tap low
   assign tap_bit = (tap_select_r == ptt_pkg::TAPSEL_UNDERFLOW) ? 1'b0
                    : tick_counter_r[tap_idx];
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tap_prev_r <= 1'b0;
         tick_prev_r <= '0;
      end else begin
         tap_prev_r <= tap_bit;
         tick_prev_r <= tick_counter_r;
      end
   end
   // Underflow mode taps the prescaler reload directly
   assign tap_hit = (tap_select_r == ptt_pkg::TAPSEL_UNDERFLOW) ?
                    underflow : (tap_prev_r && !tap_bit);
   // A match is taken once, when the counter arrives at the value
   assign hit_one = (tick_counter_r == cmp_one_r)
                    && (tick_prev_r != tick_counter_r);
   assign hit_two = (tick_counter_r == cmp_two_r)
                    && (tick_prev_r != tick_counter_r);

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tap_event_flag_r <= 1'b0;
         compare_one_flag_r <= 1'b0;
         compare_two_flag_r <= 1'b0;
      end else begin
         if (tap_hit)
            tap_event_flag_r <= 1'b1;
         else if (wr_tap && !pwdata[ptt_pkg::TAP_FLAG_BIT])
            tap_event_flag_r <= 1'b0;
         if (hit_one)
            compare_one_flag_r <= 1'b1;
         else if (wr_cmpc && !pwdata[ptt_pkg::COMPARE_ONE_FLAG_BIT])
            compare_one_flag_r <= 1'b0;
         if (hit_two)
            compare_two_flag_r <= 1'b1;
         else if (wr_cmpc && !pwdata[ptt_pkg::COMPARE_TWO_FLAG_BIT])
            compare_two_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   logic [ptt_pkg::EVT_W-1:0] evt;
   assign evt = {hit_two && compare_two_enable_r,
                 hit_one && compare_one_enable_r,
                 tap_hit && tap_irq_enable_r};
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         irq_status_r <= '0;
      else
         irq_status_r <= evt |
            (irq_status_r & ~(wr_sts ? pwdata[ptt_pkg::EVT_W-1:0]
                              : '0));
   end
   assign tap_irq = tap_event_flag_r && tap_irq_enable_r;
   assign cmp_one_irq = compare_one_flag_r && compare_one_enable_r;
   assign cmp_two_irq = compare_two_flag_r && compare_two_enable_r;
   assign irq = |(irq_status_r & irq_mask_r);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         prdata <= '0;
      else if (psel && !penable && !pwrite) begin
         case (paddr)
            ptt_pkg::ADDR_COUNTER:
               prdata <= {tick_counter_r, prescaler_counter_r};
            ptt_pkg::ADDR_PRELOAD:
               prdata <= {18'h0, tap_select_r, preload_value_r};
            ptt_pkg::ADDR_TAP_CTRL:
               prdata <= {24'h0, tap_event_flag_r, tap_irq_enable_r, 6'h0};
            ptt_pkg::ADDR_CMP_ONE: prdata <= {11'h0, cmp_one_r};
            ptt_pkg::ADDR_CMP_TWO: prdata <= {11'h0, cmp_two_r};
            ptt_pkg::ADDR_CMP_CTRL:
               prdata <= {24'h0, compare_one_flag_r, compare_two_flag_r,
                          compare_one_enable_r, compare_two_enable_r, 4'h0};
            ptt_pkg::ADDR_CNT_EN: prdata <= {30'h0, count_mode_enable_r};
            ptt_pkg::ADDR_IRQ_STATUS: prdata <= {29'h0, irq_status_r};
            ptt_pkg::ADDR_IRQ_MASK: prdata <= {29'h0, irq_mask_r};
            default: prdata <= '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_reset_clears: assert property (@(posedge sys_clk)
      !rst_n |=> tick_counter_r == '0 && prescaler_counter_r == '0)
      else $error("counters not cleared by reset");
   chk_counter_write: assert property (@(posedge sys_clk)
      disable iff (!rst_n) wr_cnt |=> tick_counter_r == '0
      && prescaler_counter_r == $past(preload_value_r))
      else $error("counter write did not restart counters");
   chk_tick_advance: assert property (@(posedge sys_clk)
      disable iff (!rst_n) underflow && !wr_cnt |=>
      tick_counter_r == $past(tick_counter_r) + 1'b1)
      else $error("tick did not advance on underflow");
   chk_presc_dec: assert property (@(posedge sys_clk)
      disable iff (!rst_n) count_ok && !underflow && !wr_cnt |=>
      prescaler_counter_r == $past(prescaler_counter_r) - 1'b1)
      else $error("prescaler did not decrement");
   chk_no_count: assert property (@(posedge sys_clk)
      disable iff (!rst_n) count_mode_enable_r == 2'h3 && !wr_cnt
      |=> $stable(tick_counter_r) && $stable(prescaler_counter_r))
      else $error("counted while disabled");
   chk_user_nowrite: assert property (@(posedge sys_clk)
      disable iff (!rst_n) acc && pwrite && !cpu_priv |=>
      $stable(preload_value_r) && $stable(count_mode_enable_r))
      else $error("user write took effect");
   chk_tap_flag_set: assert property (@(posedge sys_clk)
      disable iff (!rst_n) tap_hit |=> tap_event_flag_r)
      else $error("tap flag not set");
   chk_cmp_one_set: assert property (@(posedge sys_clk)
      disable iff (!rst_n) hit_one |=> compare_one_flag_r)
      else $error("compare one flag not set");
   chk_cmp_two_set: assert property (@(posedge sys_clk)
      disable iff (!rst_n) hit_two |=> compare_two_flag_r)
      else $error("compare two flag not set");
   chk_flag_clear: assert property (@(posedge sys_clk)
      disable iff (!rst_n) wr_cmpc && !pwdata[7] && !hit_one
      |=> !compare_one_flag_r)
      else $error("compare one flag not cleared");
   chk_tap_clear: assert property (@(posedge sys_clk)
      disable iff (!rst_n) wr_tap && !pwdata[7] && !tap_hit
      |=> !tap_event_flag_r)
      else $error("tap flag not cleared");
   chk_tap_gate: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !tap_irq_enable_r |-> !tap_irq)
      else $error("tap request while disabled");

   // ----------------------------------------------------------------
   // Counter and bus checks
   // ----------------------------------------------------------------
   chk_tick_hold: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !count_ok && !wr_cnt |=>
      $stable(tick_counter_r) && $stable(prescaler_counter_r))
      else $error("counted without enable");
   chk_reload: assert property (@(posedge sys_clk)
      disable iff (!rst_n) underflow && !wr_cnt |=>
      prescaler_counter_r == $past(preload_value_r))
      else $error("prescaler not reloaded");
   chk_priv_only: assert property (@(posedge sys_clk)
      disable iff (!rst_n) count_mode_enable_r == 2'h1 && !cpu_priv
      |=> $stable(tick_counter_r) && $stable(prescaler_counter_r))
      else $error("counted in user mode");
   chk_user_only: assert property (@(posedge sys_clk)
      disable iff (!rst_n) count_mode_enable_r == 2'h2 && cpu_priv
      && !wr_cnt |=> $stable(tick_counter_r))
      else $error("counted in privilege mode");
   chk_user_err: assert property (@(posedge sys_clk)
      disable iff (!rst_n) acc && pwrite && !cpu_priv |-> pslverr)
      else $error("user write not refused");
   chk_read_word: assert property (@(posedge sys_clk)
      disable iff (!rst_n) psel && !penable && !pwrite
      && paddr == ptt_pkg::ADDR_COUNTER |=> prdata ==
      {$past(tick_counter_r), $past(prescaler_counter_r)})
      else $error("counter word mismatch");

   // ----------------------------------------------------------------
   // Flag checks
   // ----------------------------------------------------------------
   chk_tap_hold: assert property (@(posedge sys_clk)
      disable iff (!rst_n) tap_event_flag_r
      && !(wr_tap && !pwdata[7]) |=> tap_event_flag_r)
      else $error("tap flag dropped");
   chk_tap_quiet: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !tap_hit && !tap_event_flag_r
      |=> !tap_event_flag_r)
      else $error("tap flag set without event");
   chk_tap_under: assert property (@(posedge sys_clk)
      disable iff (!rst_n) tap_select_r == ptt_pkg::TAPSEL_UNDERFLOW
      && underflow |=> tap_event_flag_r)
      else $error("underflow tap missed");
   chk_cmp_one_hold: assert property (@(posedge sys_clk)
      disable iff (!rst_n) compare_one_flag_r
      && !(wr_cmpc && !pwdata[7]) |=> compare_one_flag_r)
      else $error("compare one flag dropped");
   chk_cmp_two_hold: assert property (@(posedge sys_clk)
      disable iff (!rst_n) compare_two_flag_r
      && !(wr_cmpc && !pwdata[6]) |=> compare_two_flag_r)
      else $error("compare two flag dropped");
   chk_cmp_two_clear: assert property (@(posedge sys_clk)
      disable iff (!rst_n) wr_cmpc && !pwdata[6] && !hit_two
      |=> !compare_two_flag_r)
      else $error("compare two flag not cleared");
   chk_cmp_one_quiet: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !hit_one && !compare_one_flag_r
      |=> !compare_one_flag_r)
      else $error("compare one flag set without match");
   chk_cmp_two_quiet: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !hit_two && !compare_two_flag_r
      |=> !compare_two_flag_r)
      else $error("compare two flag set without match");

   // ----------------------------------------------------------------
   // Interrupt checks
   // ----------------------------------------------------------------
   chk_status_keep: assert property (@(posedge sys_clk)
      disable iff (!rst_n) evt[ptt_pkg::EVT_TAP] |=> irq_status_r[0])
      else $error("tap status lost");
   chk_status_clear: assert property (@(posedge sys_clk)
      disable iff (!rst_n) wr_sts && pwdata[0] && !evt[ptt_pkg::EVT_TAP]
      |=> !irq_status_r[0])
      else $error("tap status not cleared");
   chk_status_cmp: assert property (@(posedge sys_clk)
      disable iff (!rst_n) hit_one && compare_one_enable_r
      |=> irq_status_r[ptt_pkg::EVT_CMP1])
      else $error("compare one status not set");
   cov_underflow: cover property (@(posedge sys_clk) underflow);
   cov_tap: cover property (@(posedge sys_clk) tap_hit);
   cov_cmp: cover property (@(posedge sys_clk) hit_one ##1 irq);
   cov_set_clr: cover property (@(posedge sys_clk) tap_hit && wr_tap);
   cov_restart: cover property (@(posedge sys_clk) wr_cnt);
endmodule // ptt_timer
`default_nettype wire

// ==== dv/ptt_tb.sv ====
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cpu_priv = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q, q2;
   logic pready, pslverr, tap_irq, cmp_one_irq, cmp_two_irq, irq, e;
   int err_count = 0;
   int n_tests = 0;
   always #25 sys_clk = ~sys_clk;
   ptt_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_priv(cpu_priv),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tap_irq(tap_irq), .cmp_one_irq(cmp_one_irq),
      .cmp_two_irq(cmp_two_irq), .irq(irq));
   // ----------------------------------------------------------------
   // Bus and run helpers
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) err_count++;
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q2, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, q, e);
      `CHK(q, x)
   endtask
   // Counting in user-only mode: k enabled cycles
   task automatic run(input int k);
      cpu_priv <= 1'b0;
      repeat (k) @(posedge sys_clk);
      cpu_priv <= 1'b1;
      @(posedge sys_clk);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      `CHK(irq, 1'b0)
      wr(ptt_pkg::ADDR_CNT_EN, 32'h3);
      apb(1'b0, ptt_pkg::ADDR_COUNTER, 32'h0, q, e);
      `CHK(q < 32'h00008000, 1'b1)
      for (int i = 1; i < 9; i++) begin
         if (8'(4 * i) != ptt_pkg::ADDR_CNT_EN) rd_chk(8'(4 * i), 32'h0);
      end
      $display("test reset done");
   endtask
   task automatic t_access();
      wr(ptt_pkg::ADDR_PRELOAD, 32'hffffffff);
      rd_chk(ptt_pkg::ADDR_PRELOAD, 32'h00003fff);
      wr(ptt_pkg::ADDR_CMP_ONE, 32'hffffffff);
      rd_chk(ptt_pkg::ADDR_CMP_ONE, 32'h001fffff);
      wr(ptt_pkg::ADDR_CMP_TWO, 32'hffffffff);
      rd_chk(ptt_pkg::ADDR_CMP_TWO, 32'h001fffff);
      wr(ptt_pkg::ADDR_TAP_CTRL, 32'hffffffff);
      rd_chk(ptt_pkg::ADDR_TAP_CTRL, 32'h00000040);
      wr(ptt_pkg::ADDR_CMP_CTRL, 32'hffffffff);
      rd_chk(ptt_pkg::ADDR_CMP_CTRL, 32'h00000030);
      cpu_priv <= 1'b0;
      apb(1'b1, ptt_pkg::ADDR_PRELOAD, 32'h0, q, e);
      `CHK(e, 1'b1)
      rd_chk(ptt_pkg::ADDR_PRELOAD, 32'h00003fff);
      cpu_priv <= 1'b1;
      apb(1'b0, 8'h24, 32'h0, q, e);
      `CHK({e, q}, 33'h100000000)
      for (int i = 1; i < 6; i++) wr(8'(4 * i), 32'h0);
      $display("test access done");
   endtask
   task automatic t_count();
      wr(ptt_pkg::ADDR_CNT_EN, 32'h2);
      wr(ptt_pkg::ADDR_PRELOAD, 32'h3);
      wr(ptt_pkg::ADDR_COUNTER, 32'h0);
      rd_chk(ptt_pkg::ADDR_COUNTER, 32'h00000003);
      run(10);
      rd_chk(ptt_pkg::ADDR_COUNTER, 32'h00001001);
      wr(ptt_pkg::ADDR_COUNTER, 32'h5a5a5a5a);
      rd_chk(ptt_pkg::ADDR_COUNTER, 32'h00000003);
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            wr(ptt_pkg::ADDR_CNT_EN, 32'(m));
            cpu_priv <= 1'(p);
            apb(1'b0, ptt_pkg::ADDR_COUNTER, 32'h0, q, e);
            repeat (4) @(posedge sys_clk);
            apb(1'b0, ptt_pkg::ADDR_COUNTER, 32'h0, q2, e);
            cpu_priv <= 1'b1;
            e = (m == 0) || (m == 1 && p == 1) || (m == 2 && p == 0);
            `CHK(q !== q2, e)
         end
      end
      wr(ptt_pkg::ADDR_CNT_EN, 32'h2);
      $display("test count done");
   endtask
   task automatic t_tap();
      wr(ptt_pkg::ADDR_PRELOAD, 32'h00003800);
      wr(ptt_pkg::ADDR_COUNTER, 32'h0);
      wr(ptt_pkg::ADDR_TAP_CTRL, 32'h40);
      wr(ptt_pkg::ADDR_IRQ_MASK, 32'h1);
      run(3);
      rd_chk(ptt_pkg::ADDR_TAP_CTRL, 32'h000000c0);
      `CHK(tap_irq, 1'b1)
      rd_chk(ptt_pkg::ADDR_IRQ_STATUS, 32'h1);
      `CHK(irq, 1'b1)
      wr(ptt_pkg::ADDR_IRQ_MASK, 32'h0);
      `CHK(irq, 1'b0)
      wr(ptt_pkg::ADDR_CNT_EN, 32'h0);
      wr(ptt_pkg::ADDR_TAP_CTRL, 32'h40);
      wr(ptt_pkg::ADDR_CNT_EN, 32'h3);
      rd_chk(ptt_pkg::ADDR_TAP_CTRL, 32'h000000c0);
      wr(ptt_pkg::ADDR_TAP_CTRL, 32'h0);
      rd_chk(ptt_pkg::ADDR_TAP_CTRL, 32'h0);
      `CHK(tap_irq, 1'b0)
      wr(ptt_pkg::ADDR_IRQ_STATUS, 32'h1);
      rd_chk(ptt_pkg::ADDR_IRQ_STATUS, 32'h0);
      wr(ptt_pkg::ADDR_CNT_EN, 32'h2);
      run(2);
      rd_chk(ptt_pkg::ADDR_TAP_CTRL, 32'h00000080);
      `CHK(tap_irq, 1'b0)
      wr(ptt_pkg::ADDR_PRELOAD, 32'h00003000);
      wr(ptt_pkg::ADDR_COUNTER, 32'h0);
      wr(ptt_pkg::ADDR_TAP_CTRL, 32'h40);
      run(7);
      rd_chk(ptt_pkg::ADDR_TAP_CTRL, 32'h00000040);
      run(2);
      rd_chk(ptt_pkg::ADDR_TAP_CTRL, 32'h000000c0);
      $display("test tap done");
   endtask
   task automatic t_cmp();
      wr(ptt_pkg::ADDR_TAP_CTRL, 32'h0);
      wr(ptt_pkg::ADDR_IRQ_STATUS, 32'h7);
      wr(ptt_pkg::ADDR_CMP_ONE, 32'h5);
      wr(ptt_pkg::ADDR_CMP_TWO, 32'h7);
      wr(ptt_pkg::ADDR_COUNTER, 32'h0);
      wr(ptt_pkg::ADDR_CMP_CTRL, 32'h30);
      run(6);
      rd_chk(ptt_pkg::ADDR_CMP_CTRL, 32'h000000b0);
      `CHK({cmp_one_irq, cmp_two_irq}, 2'b10)
      run(2);
      rd_chk(ptt_pkg::ADDR_CMP_CTRL, 32'h000000f0);
      rd_chk(ptt_pkg::ADDR_IRQ_STATUS, 32'h6);
      wr(ptt_pkg::ADDR_CMP_CTRL, 32'h80);
      rd_chk(ptt_pkg::ADDR_CMP_CTRL, 32'h00000080);
      `CHK({cmp_one_irq, cmp_two_irq}, 2'b00)
      wr(ptt_pkg::ADDR_IRQ_MASK, 32'h6);
      `CHK(irq, 1'b1)
      rst_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      `CHK(irq, 1'b0)
      rd_chk(ptt_pkg::ADDR_CMP_CTRL, 32'h0);
      $display("test compare done");
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_access();
      t_count();
      t_tap();
      t_cmp();
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      end_sim();
   end
endmodule // tb
`default_nettype wire
